// File: tb/bmad_cpu_model.sv
// Partner model: the on-board processor and an external bus master.
`timescale 1ns/100ps
module bmad_cpu_model (
	// Clock, reset and access answer.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic cpu_ready_i,
	// Access request.
	output logic cpu_req_o,
	output logic [23:0] cpu_addr_o,
	output logic pva_o,
	// External master.
	output logic ext_req_o,
	output logic [23:0] ext_addr_o
);
	initial {cpu_req_o, cpu_addr_o, pva_o, ext_req_o, ext_addr_o} = '0;

	// The external master roams the dual-port block and the block just below it.
	always @(posedge core_clk_i) begin
		ext_req_o <= rst_n_i && ($urandom_range(1, 0) == 1);
		ext_addr_o <= 24'hFE8000 + 24'($urandom_range(32767, 0));
	end

	// One access: a request pulse, wait for ready, then a random idle gap.
	task automatic access(input logic pva, input logic [23:0] a);
		cpu_req_o <= 1'b1;
		cpu_addr_o <= a;
		pva_o <= pva;
		@(posedge core_clk_i);
		cpu_req_o <= 1'b0;
		cpu_addr_o <= ~a;
		do @(posedge core_clk_i); while (cpu_ready_i !== 1'b1);
		repeat ($urandom_range(2, 0)) @(posedge core_clk_i);
	endtask : access
endmodule : bmad_cpu_model

// File: tb/bmad_top_checker.sv
// Concurrent checks on the decoder's target selects, wait counts and external dual-port hit.
`timescale 1ns/100ps
module bmad_top_checker (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// On-board CPU access.
	input wire logic cpu_req_i,
	input wire logic [23:0] cpu_addr_i,
	input wire logic protected_virtual_addressing_i,
	input wire logic cpu_ready_o,
	input wire logic sel_upper_rom_pair_o,
	input wire logic sel_lower_rom_pair_o,
	input wire logic sel_dual_port_o,
	input wire logic sel_expansion_o,
	input wire logic sel_system_bus_o,
	// External master.
	input wire logic ext_req_i,
	input wire logic [23:0] ext_addr_i,
	input wire logic ext_dual_port_sel_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// An access is taken only while no select is up; the external hit is delayed one cycle.
	logic [4:0] sels;
	logic take;
	logic pva;
	logic rla;
	logic ext_hit_q;
	assign sels = {sel_upper_rom_pair_o, sel_lower_rom_pair_o, sel_dual_port_o, sel_expansion_o, sel_system_bus_o};
	assign take = cpu_req_i && (sels == 5'h00);
	assign pva = take && protected_virtual_addressing_i;
	assign rla = take && !protected_virtual_addressing_i;
	always_ff @(posedge core_clk_i) begin
		ext_hit_q <= rst_n_i && ext_req_i && (ext_addr_i[23:14] == 10'h3FB);
	end

	// Steps of a dual-port access and of a local access before ready.
	sequence dp_hold;
		(sel_dual_port_o && !cpu_ready_o) [*3];
	endsequence
	sequence loc_wait;
		!cpu_ready_o [*2] ##[1:3] cpu_ready_o;
	endsequence

	AST_ONE_TARGET: assert property ($onehot0(sels))
		else $error("More than one target selected.");
	AST_READY_SEL: assert property (cpu_ready_o |-> $onehot(sels) ##1 (sels == 5'h00 && !cpu_ready_o))
		else $error("Ready without a single target or not a pulse.");
	AST_DP_WAIT: assert property ($rose(sel_dual_port_o) |-> dp_hold ##1 cpu_ready_o)
		else $error("Dual-port access length wrong.");
	AST_LOC_WAIT: assert property ($rose(sels[4] || sels[3]) |-> loc_wait)
		else $error("Local access length out of range.");
	AST_PROT_SYS: assert property (pva && cpu_addr_i >= 24'hE00000 && cpu_addr_i <= 24'hFEBFFF |=>
		sel_system_bus_o)
		else $error("Protected system bus range not selected.");
	AST_PROT_DP: assert property (pva && cpu_addr_i[23:14] == 10'h3FB |=> sel_dual_port_o)
		else $error("Protected dual-port block not selected.");
	AST_PROT_ROM: assert property (pva && cpu_addr_i[23:16] == 8'hFF |=>
		($past(cpu_addr_i[15]) ? sel_upper_rom_pair_o : sel_lower_rom_pair_o))
		else $error("Protected socket pair decode wrong.");
	AST_REAL_DP: assert property (rla && cpu_addr_i[19:14] == 6'h3B |=> sel_dual_port_o)
		else $error("Real mode dual-port block not selected.");
	AST_EXT_DP: assert property (ext_dual_port_sel_o == ext_hit_q)
		else $error("External dual-port select wrong.");
endmodule : bmad_top_checker

// File: tb/board_memory_address_decoder_test.sv
// Self-checking bench for the board memory address decoder.
`timescale 1ns/100ps
module board_memory_address_decoder_test;
	// Design hookup and bench state.
	logic core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0, prdata_o, rd;
	logic pready_o, pslverr_o, cpu_req_i, protected_virtual_addressing_i, cpu_ready_o, ext_req_i, ext_dual_port_sel_o;
	logic err;
	logic [12:0] exp_v;
	logic [1:0] primary_map_straps_i = 2'h1;
	logic [23:0] cpu_addr_i, ext_addr_i;
	logic sel_upper_rom_pair_o, sel_lower_rom_pair_o, sel_dual_port_o, sel_expansion_o, sel_system_bus_o;
	wire [4:0] sels = {sel_upper_rom_pair_o, sel_lower_rom_pair_o, sel_dual_port_o, sel_expansion_o, sel_system_bus_o};
	int n_errors = 0, comparisons = 0, cnt = 0;
	int ws[5] = '{1, 1, 2, 1, 1};
	logic [12:0] exp_q[$];
	// Mode bit and block address; target 0 upper, 1 lower, 2 dual-port, 3 expansion, 4 system bus.
	logic [24:0] tab[16] = '{25'h1E00000, 25'h1FE8000, 25'h1FEC000, 25'h1FF0000, 25'h1FF4000, 25'h1FF8000,
		25'h1FFC000, 25'h1000000, 25'h1DFC000, 25'h00E0000, 25'h00E8000, 25'h00EC000, 25'h00F0000,
		25'h00F8000, 25'h0000000, 25'h00DC000};
	int tgt[16] = '{4, 4, 2, 1, 1, 0, 0, 3, 3, 4, 4, 2, 1, 0, 3, 3};

	initial forever #20 core_clk_i = ~core_clk_i;

	bmad_top dut (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .primary_map_straps_i, .cpu_req_i, .cpu_addr_i, .protected_virtual_addressing_i,
		.cpu_ready_o, .sel_upper_rom_pair_o, .sel_lower_rom_pair_o, .sel_dual_port_o, .sel_expansion_o,
		.sel_system_bus_o, .ext_req_i, .ext_addr_i, .ext_dual_port_sel_o);
	bmad_cpu_model cpu (.core_clk_i, .rst_n_i, .cpu_ready_i(cpu_ready_o), .cpu_req_o(cpu_req_i),
		.cpu_addr_o(cpu_addr_i), .pva_o(protected_virtual_addressing_i), .ext_req_o(ext_req_i),
		.ext_addr_o(ext_addr_i));

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// One APB transfer: setup, access until ready, then release for a cycle.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge core_clk_i);
		penable_i <= 1'b1;
		do @(posedge core_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : apb

	// Every map entry once, random offset in the block, random ignored high bits in real mode.
	task automatic run_map(string name);
		logic [23:0] a;
		for (int i = 0; i < 16; i++) begin
			a = tab[i][23:0] | (24'($urandom) & (tab[i][24] ? 24'h003FFF : 24'hF03FFF));
			exp_q.push_back({5'h10 >> tgt[i], 8'(ws[tgt[i]] + 2)});
			cpu.access(tab[i][24], a);
		end
		@(posedge core_clk_i);
		check("pending", exp_q.size(), 0);
		$display("test %s done", name);
	endtask : run_map

	// Monitor: the selects and the access length are compared with the oldest note.
	always @(posedge core_clk_i) begin
		if (cpu_ready_o === 1'b1) begin
			exp_v = exp_q.size() ? exp_q.pop_front() : 13'h1FFF;
			check("access", {sels, 8'(cnt + 1)}, exp_v);
			cnt = 0;
		end else if (|sels)
			cnt++;
	end

	// Main sequence.
	initial begin
		void'($urandom(21298));
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		apb(1'b0, 12'h000, $urandom);
		check("ctrl reset", rd, 32'h000012A5);
		run_map("default_map");
		apb(1'b1, 12'h000, 32'h00004165);
		ws = '{3, 2, 2, 0, 4};
		apb(1'b0, 12'h000, $urandom);
		check("ctrl", rd, 32'h00004165);
		run_map("slow_map");
		// Map 3 with a separate lower pair in real mode: lower, the gap above it, and the upper pair.
		apb(1'b1, 12'h000, 32'h00001337);
		exp_q.push_back({5'h08, 8'h04});
		cpu.access(1'b0, 24'h0C0000 | (24'($urandom) & 24'hF03FFF));
		exp_q.push_back({5'h01, 8'h03});
		cpu.access(1'b0, 24'h0C4000 | (24'($urandom) & 24'hF03FFF));
		exp_q.push_back({5'h10, 8'h03});
		cpu.access(1'b0, 24'h0FC000 | (24'($urandom) & 24'hF03FFF));
		apb(1'b0, 12'h004, $urandom);
		check("status", rd, 32'h00000001);
		apb(1'b0, 12'h00C, $urandom);
		check("count", rd, 32'h00000023);
		check("pending", exp_q.size(), 0);
		$display("test split_map done");
		apb(1'b0, 12'h010, $urandom);
		check("unmapped err", err, 1);
		check("unmapped data", rd, 0);
		$display("test registers done");
		final_report();
	end

	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		repeat (2000) @(posedge core_clk_i);
		n_errors++;
		final_report();
	end
endmodule : board_memory_address_decoder_test

bind bmad_top bmad_top_checker chk (.core_clk_i, .rst_n_i, .cpu_req_i, .cpu_addr_i, .protected_virtual_addressing_i,
	.cpu_ready_o, .sel_upper_rom_pair_o, .sel_lower_rom_pair_o, .sel_dual_port_o, .sel_expansion_o,
	.sel_system_bus_o, .ext_req_i, .ext_addr_i, .ext_dual_port_sel_o);

// File: verilog/bmad_cfg.svh
// Constants for the board memory address decoder: field positions, map blocks, wait counts and register offsets.
// Functional notes
// - Protected default: E00000-FEBFFF goes to system bus.
// - Protected default: FEC000-FEFFFF selects dual-port memory.
// - Protected default: FF0000-FF7FFF selects lower socket pair.
// - Protected default: FF8000-FFFFFF selects upper boot pair.
// - Real mode dual-port memory starts at 0EC000.
// - On-board dual-port access always takes two wait-states.
// - Each socket pair wait count selectable one to three.
// - Default wait count is one per socket pair.
// - Compare 20 bits real, 24 bits protected.
// - Local memory decoded in fixed 16K blocks.
// - Upper socket pair always ends at map top.
// - Lower pair contiguous below upper, or separate region.
// - Primary stage picks one of four strap maps.
// - Secondary level sets each pair's size and justification; code sizes only the lower pair, upper pair size follows the primary map.
// - Dual-port memory is one contiguous region.
// - Dual-port decodes one 16K block, both sides.
// - Local decode covers up to 256K bytes total.
// - Real default: 0E0000-0EBFFF system bus, above expansion.
`ifndef BMAD_CFG_SVH
`define BMAD_CFG_SVH

// Address fields: 16K-byte block index.
`define BMAD_ADDR_MSB 23
`define BMAD_REAL_MSB 19
`define BMAD_BLK_LSB 14
`define BMAD_REAL_TOP_NIB 4'hF

// Upper pair base block per primary map option, always top-justified.
`define BMAD_UP_BASE_P0 10'h3FF
`define BMAD_UP_BASE_P1 10'h3FE
`define BMAD_UP_BASE_P2 10'h3FC
`define BMAD_UP_BASE_P3 10'h3F8

// Separate lower pair region for secondary options four to seven.
`define BMAD_SPLIT_BASE 10'h3F0
`define BMAD_SPLIT_TOP_S4 10'h3F0
`define BMAD_SPLIT_TOP_S5 10'h3F0
`define BMAD_SPLIT_TOP_S6 10'h3F1
`define BMAD_SPLIT_TOP_S7 10'h3F3

// Dual-port block, expansion limits (first block past the region).
`define BMAD_DP_BLK 10'h3FB
`define BMAD_XB_PV_LIM 10'h380
`define BMAD_XB_RL_LIM01 6'h38
`define BMAD_XB_RL_LIM23 6'h28
`define BMAD_PRIM_FULL 2'h3

// Wait-state counts.
`define BMAD_DP_WAIT 3'h2
`define BMAD_LOC_WAIT_MIN 2'h1
`define BMAD_XB_WAIT_MAX 3'h4

// APB register byte offsets and control field positions.
`define BMAD_OFS_CTRL 12'h000
`define BMAD_OFS_STATUS 12'h004
`define BMAD_OFS_ADDR 12'h008
`define BMAD_OFS_COUNT 12'h00C
`define BMAD_F_PRIM 0
`define BMAD_F_SEC 2
`define BMAD_F_WSUP 5
`define BMAD_F_WSLO 7
`define BMAD_F_WSXB 9
`define BMAD_F_WSSB 12
`define BMAD_RST_PRIM 2'h1
`define BMAD_RST_SEC 3'h1
`define BMAD_RST_WSLOC 2'h1
`define BMAD_RST_WSEXT 3'h1

`endif

// File: verilog/bmad_dec_if.sv
// Interface between the access sequencer and the map decode.
`timescale 1ns/100ps
interface bmad_dec_if;
	logic [23:0] addr;
	logic real_mode;
	logic [1:0] prim;
	logic [2:0] sec;
	bmad_pkg::bmad_target_t target;

	modport requester(output addr, real_mode, prim, sec, input target);
	modport decoder(input addr, real_mode, prim, sec, output target);
endinterface : bmad_dec_if

// File: verilog/bmad_map_decode.sv
// Combinational memory map decode for on-board CPU accesses.
`timescale 1ns/100ps
`include "bmad_cfg.svh"
module bmad_map_decode (
	// Decode request and answer.
	bmad_dec_if.decoder dec
);

	logic [9:0] blk;
	logic [9:0] up_base;
	logic [9:0] lo_base;
	logic [9:0] lo_top;
	logic [9:0] sz;
	logic [5:0] real_blk;
	logic xb_hit;

	// Upper pair base block for a map option.
	function automatic logic [9:0] bmad_up_base(input logic [1:0] opt);
		logic [9:0] b;
		b = `BMAD_UP_BASE_P0;
		unique case (opt)
			2'h0: b = `BMAD_UP_BASE_P0;
			2'h1: b = `BMAD_UP_BASE_P1;
			2'h2: b = `BMAD_UP_BASE_P2;
			2'h3: b = `BMAD_UP_BASE_P3;
		endcase
		return b;
	endfunction : bmad_up_base

	// Block index, region bounds and a priority pick of one target.
	always_comb begin
		real_blk = dec.addr[`BMAD_REAL_MSB:`BMAD_BLK_LSB];
		blk = dec.real_mode ? {`BMAD_REAL_TOP_NIB, real_blk} : dec.addr[`BMAD_ADDR_MSB:`BMAD_BLK_LSB];
		up_base = bmad_up_base(dec.prim);
		sz = 10'h000 - bmad_up_base(dec.sec[1:0]);
		lo_base = bmad_up_base(dec.sec[1:0]) - sz;
		lo_top = bmad_up_base(dec.sec[1:0]) - 10'h001;
		if (dec.sec[2]) begin
			lo_base = `BMAD_SPLIT_BASE;
			unique case (dec.sec[1:0])
				2'h0: lo_top = `BMAD_SPLIT_TOP_S4;
				2'h1: lo_top = `BMAD_SPLIT_TOP_S5;
				2'h2: lo_top = `BMAD_SPLIT_TOP_S6;
				2'h3: lo_top = `BMAD_SPLIT_TOP_S7;
			endcase
		end
		if (dec.real_mode) begin
			xb_hit = real_blk < ((dec.prim[1]) ? `BMAD_XB_RL_LIM23 : `BMAD_XB_RL_LIM01);
		end else begin
			xb_hit = blk < `BMAD_XB_PV_LIM;
		end
		if (blk >= up_base) begin
			dec.target = bmad_pkg::BMAD_TGT_UPPER;
		end else if (blk >= lo_base && blk <= lo_top) begin
			dec.target = bmad_pkg::BMAD_TGT_LOWER;
		end else if (blk == `BMAD_DP_BLK) begin
			dec.target = bmad_pkg::BMAD_TGT_DUAL;
		end else if (xb_hit) begin
			dec.target = bmad_pkg::BMAD_TGT_EXPN;
		end else begin
			dec.target = bmad_pkg::BMAD_TGT_SYS;
		end
	end

endmodule : bmad_map_decode

// File: verilog/bmad_pkg.sv
// Types shared by the board memory address decoder modules.
package bmad_pkg;

	// Access target chosen by the map decode.
	typedef enum logic [2:0] {
		BMAD_TGT_NONE = 3'h0,
		BMAD_TGT_UPPER = 3'h1,
		BMAD_TGT_LOWER = 3'h2,
		BMAD_TGT_DUAL = 3'h3,
		BMAD_TGT_EXPN = 3'h4,
		BMAD_TGT_SYS = 3'h5
	} bmad_target_t;

	// Access sequencer states, Gray coded along idle, wait, done.
	typedef enum logic [1:0] {
		BMAD_ST_IDLE = 2'b00,
		BMAD_ST_WAIT = 2'b01,
		BMAD_ST_DONE = 2'b11
	} bmad_state_t;

endpackage : bmad_pkg

// File: verilog/bmad_top.sv
// Top of the board memory address decoder: APB registers, access sequencer and external dual-port hit.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "bmad_cfg.svh"
module bmad_top (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Board straps.
	input wire logic [1:0] primary_map_straps_i,
	// On-board CPU access.
	input wire logic cpu_req_i,
	input wire logic [23:0] cpu_addr_i,
	input wire logic protected_virtual_addressing_i,
	output logic cpu_ready_o,
	// Target selects.
	output logic sel_upper_rom_pair_o,
	output logic sel_lower_rom_pair_o,
	output logic sel_dual_port_o,
	output logic sel_expansion_o,
	output logic sel_system_bus_o,
	// External system-bus master access.
	input wire logic ext_req_i,
	input wire logic [23:0] ext_addr_i,
	output logic ext_dual_port_sel_o
);

	// Configuration fields held by the control register.
	logic [1:0] prim;
	logic [2:0] sec;
	logic [1:0] ws_up;
	logic [1:0] ws_lo;
	logic [2:0] ws_xb;
	logic [2:0] ws_sb;
	logic strap_pending;

	// Access sequencer state and status.
	bmad_pkg::bmad_state_t state;
	bmad_pkg::bmad_state_t next_state;
	bmad_pkg::bmad_target_t last_target;
	logic [23:0] last_addr;
	logic [15:0] access_count;
	logic [2:0] next_wait;
	logic take;
	logic expire;

	// APB decode helpers.
	logic apb_setup;
	logic apb_commit;
	logic ofs_hit;
	logic [31:0] next_rdata;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic map_mismatch;

	// Map decode over the carrier interface.
	bmad_dec_if dec_bus();

	assign dec_bus.addr = cpu_addr_i;
	assign dec_bus.real_mode = !protected_virtual_addressing_i;
	assign dec_bus.prim = prim;
	assign dec_bus.sec = sec;

	bmad_map_decode u_decode (
		.dec(dec_bus.decoder)
	);

	// A request is only taken while the sequencer is idle.
	assign take = cpu_req_i && (state == bmad_pkg::BMAD_ST_IDLE);

	// Wait count for the target chosen this cycle.
	always_comb begin
		next_wait = `BMAD_DP_WAIT;
		unique case (dec_bus.target)
			bmad_pkg::BMAD_TGT_UPPER: next_wait = {1'b0, ws_up};
			bmad_pkg::BMAD_TGT_LOWER: next_wait = {1'b0, ws_lo};
			bmad_pkg::BMAD_TGT_DUAL: next_wait = `BMAD_DP_WAIT;
			bmad_pkg::BMAD_TGT_EXPN: next_wait = ws_xb;
			bmad_pkg::BMAD_TGT_SYS: next_wait = ws_sb;
			default: next_wait = `BMAD_DP_WAIT;
		endcase
	end

	bmad_wait_counter u_wait (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.load_i(take),
		.count_i(next_wait),
		.expire_o(expire)
	);

	// Sequencer next state: idle, wait out the count, one done cycle.
	always_comb begin
		next_state = state;
		unique case (state)
			bmad_pkg::BMAD_ST_IDLE: begin
				if (cpu_req_i) begin
					next_state = bmad_pkg::BMAD_ST_WAIT;
				end
			end
			bmad_pkg::BMAD_ST_WAIT: begin
				if (expire) begin
					next_state = bmad_pkg::BMAD_ST_DONE;
				end
			end
			bmad_pkg::BMAD_ST_DONE: next_state = bmad_pkg::BMAD_ST_IDLE;
			default: next_state = bmad_pkg::BMAD_ST_IDLE;
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= bmad_pkg::BMAD_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Ready pulses once the selected target's wait-states have passed.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cpu_ready_o <= 1'b0;
		end else begin
			cpu_ready_o <= (state == bmad_pkg::BMAD_ST_WAIT) && expire;
		end
	end

	// One-hot target selects, held from the take until the ready cycle ends.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sel_upper_rom_pair_o <= 1'b0;
			sel_lower_rom_pair_o <= 1'b0;
			sel_dual_port_o <= 1'b0;
			sel_expansion_o <= 1'b0;
			sel_system_bus_o <= 1'b0;
		end else if (take) begin
			sel_upper_rom_pair_o <= dec_bus.target == bmad_pkg::BMAD_TGT_UPPER;
			sel_lower_rom_pair_o <= dec_bus.target == bmad_pkg::BMAD_TGT_LOWER;
			sel_dual_port_o <= dec_bus.target == bmad_pkg::BMAD_TGT_DUAL;
			sel_expansion_o <= dec_bus.target == bmad_pkg::BMAD_TGT_EXPN;
			sel_system_bus_o <= dec_bus.target == bmad_pkg::BMAD_TGT_SYS;
		end else if (state == bmad_pkg::BMAD_ST_DONE) begin
			sel_upper_rom_pair_o <= 1'b0;
			sel_lower_rom_pair_o <= 1'b0;
			sel_dual_port_o <= 1'b0;
			sel_expansion_o <= 1'b0;
			sel_system_bus_o <= 1'b0;
		end
	end

	// Status capture: last target, last address and a running count of accesses.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			last_target <= bmad_pkg::BMAD_TGT_NONE;
			last_addr <= 24'h000000;
			access_count <= 16'h0000;
		end else if (take) begin
			last_target <= dec_bus.target;
			last_addr <= cpu_addr_i;
			access_count <= access_count + 16'h0001;
		end
	end

	// External masters see the dual-port block at its protected address in any CPU mode.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ext_dual_port_sel_o <= 1'b0;
		end else begin
			ext_dual_port_sel_o <= ext_req_i &&
				(ext_addr_i[`BMAD_ADDR_MSB:`BMAD_BLK_LSB] == `BMAD_DP_BLK);
		end
	end

	// APB phases: setup edge prepares the answer, access edge commits it.
	assign apb_setup = psel_i && !penable_i;
	assign apb_commit = psel_i && penable_i && pready_o;
	assign ofs_hit = (paddr_i == `BMAD_OFS_CTRL) || (paddr_i == `BMAD_OFS_STATUS) ||
		(paddr_i == `BMAD_OFS_ADDR) || (paddr_i == `BMAD_OFS_COUNT);

	// A secondary option must belong to the chosen primary map.
	assign map_mismatch = sec[2] ? (prim != `BMAD_PRIM_FULL) : (sec[1:0] != prim);

	// Register images for reads.
	always_comb begin
		ctrl_word = 32'h00000000;
		ctrl_word[`BMAD_F_PRIM +: 2] = prim;
		ctrl_word[`BMAD_F_SEC +: 3] = sec;
		ctrl_word[`BMAD_F_WSUP +: 2] = ws_up;
		ctrl_word[`BMAD_F_WSLO +: 2] = ws_lo;
		ctrl_word[`BMAD_F_WSXB +: 3] = ws_xb;
		ctrl_word[`BMAD_F_WSSB +: 3] = ws_sb;
		status_word = {27'h0000000, map_mismatch, state != bmad_pkg::BMAD_ST_IDLE, last_target};
		next_rdata = 32'h00000000;
		if (paddr_i == `BMAD_OFS_CTRL) begin
			next_rdata = ctrl_word;
		end else if (paddr_i == `BMAD_OFS_STATUS) begin
			next_rdata = status_word;
		end else if (paddr_i == `BMAD_OFS_ADDR) begin
			next_rdata = {8'h00, last_addr};
		end else if (paddr_i == `BMAD_OFS_COUNT) begin
			next_rdata = {16'h0000, access_count};
		end
	end

	// APB answer: ready in the first cycle of the access phase, error on unmapped offsets.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
		end else if (apb_setup) begin
			pready_o <= 1'b1;
			pslverr_o <= !ofs_hit;
			prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// Primary map: taken from the straps after reset, then software may change it.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			strap_pending <= 1'b1;
			prim <= `BMAD_RST_PRIM;
		end else if (strap_pending) begin
			strap_pending <= 1'b0;
			prim <= primary_map_straps_i;
		end else if (apb_commit && pwrite_i && paddr_i == `BMAD_OFS_CTRL) begin
			prim <= pwdata_i[`BMAD_F_PRIM +: 2];
		end
	end

	// Secondary size option.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sec <= `BMAD_RST_SEC;
		end else if (apb_commit && pwrite_i && paddr_i == `BMAD_OFS_CTRL) begin
			sec <= pwdata_i[`BMAD_F_SEC +: 3];
		end
	end

	// Local pair wait counts, each one to three, a zero write stored as one.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ws_up <= `BMAD_RST_WSLOC;
			ws_lo <= `BMAD_RST_WSLOC;
		end else if (apb_commit && pwrite_i && paddr_i == `BMAD_OFS_CTRL) begin
			ws_up <= (pwdata_i[`BMAD_F_WSUP +: 2] == 2'h0) ? `BMAD_LOC_WAIT_MIN : pwdata_i[`BMAD_F_WSUP +: 2];
			ws_lo <= (pwdata_i[`BMAD_F_WSLO +: 2] == 2'h0) ? `BMAD_LOC_WAIT_MIN : pwdata_i[`BMAD_F_WSLO +: 2];
		end
	end

	// Off-board wait counts, zero to four, larger writes stored as four.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ws_xb <= `BMAD_RST_WSEXT;
			ws_sb <= `BMAD_RST_WSEXT;
		end else if (apb_commit && pwrite_i && paddr_i == `BMAD_OFS_CTRL) begin
			ws_xb <= (pwdata_i[`BMAD_F_WSXB +: 3] > `BMAD_XB_WAIT_MAX) ? `BMAD_XB_WAIT_MAX : pwdata_i[`BMAD_F_WSXB +: 3];
			ws_sb <= (pwdata_i[`BMAD_F_WSSB +: 3] > `BMAD_XB_WAIT_MAX) ? `BMAD_XB_WAIT_MAX : pwdata_i[`BMAD_F_WSSB +: 3];
		end
	end

endmodule : bmad_top

// File: verilog/bmad_wait_counter.sv
// Down-counter that times the wait-states of one access.
`timescale 1ns/100ps
module bmad_wait_counter (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Load and expiry.
	input wire logic load_i,
	input wire logic [2:0] count_i,
	output logic expire_o
);

	logic [2:0] cnt;
	logic active;

	// Load the count, then step down once per cycle until zero.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cnt <= 3'h0;
			active <= 1'b0;
		end else if (load_i) begin
			cnt <= count_i;
			active <= 1'b1;
		end else if (active) begin
			if (cnt == 3'h0) begin
				active <= 1'b0;
			end else begin
				cnt <= cnt - 3'h1;
			end
		end
	end

	assign expire_o = active && (cnt == 3'h0);

endmodule : bmad_wait_counter
